/* design/srm_pkg.sv */
package srm_pkg;
	// register byte offsets
	localparam logic [7:0] SRM_CTRL0_OFS = 8'h00;
	localparam logic [7:0] SRM_CTRL1_OFS = 8'h04;
	localparam logic [7:0] SRM_RATIO0_OFS = 8'h08;
	localparam logic [7:0] SRM_RATIO1_OFS = 8'h0C;
	localparam logic [7:0] SRM_VLIM0_OFS = 8'h10;
	localparam logic [7:0] SRM_VLIM1_OFS = 8'h14;
	localparam logic [7:0] SRM_STATUS_OFS = 8'h18;
	localparam logic [7:0] SRM_IDENT_OFS = 8'h1C;

	// control fields
	localparam int SRM_CTRL_EN_BIT = 0;
	localparam int SRM_CTRL_IDX_BIT = 1;
	localparam int SRM_CTRL_SECOND_BIT = 2;
	localparam int SRM_CTRL_MODE_LSB = 3;
	localparam int SRM_CTRL_ERRPOL_BIT = 5;
	localparam int SRM_CTRL_W = 6;
	localparam logic [5:0] SRM_CTRL_RST = 6'h00;

	// status fields, per axis at SRM_STAT_AXIS_STRIDE
	localparam int SRM_STAT_SHEAR_BIT = 0;
	localparam int SRM_STAT_AUX_BIT = 1;
	localparam int SRM_STAT_ACTIVE_BIT = 2;
	localparam int SRM_STAT_SPEED_BIT = 3;
	localparam int SRM_STAT_AXIS_STRIDE = 8;

	// voltage limit fields
	localparam int SRM_VLIM_LO_LSB = 0;
	localparam int SRM_VLIM_HI_LSB = 8;
	localparam logic [15:0] SRM_VLIM_RST = 16'hFF00;

	// ratio f_ab/f_z, unsigned q16.16
	localparam logic [31:0] SRM_RATIO_ONE = 32'h0001_0000;
	localparam logic [31:0] SRM_RATIO_RST = 32'h0001_0000;
	localparam int SRM_FRAC_BITS = 16;

	// feasibility tolerances
	localparam logic [40:0] SRM_TOL_HI_HALVES = 41'h000_0000_000F;
	localparam logic [40:0] SRM_TOL_LO_AB = 41'h000_0004_8000;
	localparam logic [3:0] SRM_WARM_HI_Z = 4'h8;
	localparam logic [3:0] SRM_WARM_LO_AB = 4'h5;

	// auxiliary track modes
	typedef enum logic [1:0] {
		SRM_AUX_OFF,
		SRM_AUX_ERROR,
		SRM_AUX_VOLTAGE,
		SRM_AUX_SPARE
	} srm_aux_type;
	localparam int SRM_AUX_FULL_SCALE_MV = 30000;
	localparam int SRM_AUX_ZERO_MV = 0;

	// minimum speed
	localparam longint unsigned SRM_CLK_HZ = 64'd100000000;
	localparam longint unsigned SRM_MIN_FREQ_MHZ = 64'd10;
	localparam longint unsigned SRM_MIN_PERIOD_CYC =
		(SRM_CLK_HZ * 64'd1000 + SRM_MIN_FREQ_MHZ - 64'd1) / SRM_MIN_FREQ_MHZ;
	localparam int SRM_TIMER_W = 34;

	// arbitrary identification value
	localparam logic [31:0] SRM_IDENT = 32'h5352_0001;
endpackage

/* design/srm_pin_sync.sv */
`timescale 1ns/100ps
module srm_pin_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pin and synchronised views
	input wire logic pin,
	output logic level,
	output logic rise
);
	logic meta;
	logic hold;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			level <= 1'b0;
			hold <= 1'b0;
			rise <= 1'b0;
		end else begin
			meta <= pin;
			level <= meta;
			hold <= level;
			rise <= level & ~hold;
		end
	end
endmodule // srm_pin_sync

/* design/srm_monitor.sv */
`timescale 1ns/100ps
// Functional notes
// - supervision waits for minimum speed and used-up feasibility tolerance
// - minimum speed: reference track above 10 mHz, Z if ratio >= 1 else AB
// - ratio >= 1: tolerance 7.5 Z pulses, ratio times 7.5 AB pulses
// - ratio < 1: tolerance 4.5 AB pulses, 4.5 / ratio Z pulses
// - index required for supervision; without index the Z input is ignored and supervision stays off
// - a proximity switch on track Z serves as reference pulse
// - auxiliary track as encoder error input raises a fault
// - voltage mode flags aux level outside configured limits
// - index may come from a second sensor instead of track Z
// - implausible sensor signal reported per axis
module srm_monitor #(
	parameter logic [srm_pkg::SRM_TIMER_W-1:0] MIN_PERIOD_CYC =
		srm_pkg::SRM_TIMER_W'(srm_pkg::SRM_MIN_PERIOD_CYC)
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sensor tracks per axis
	input wire logic [1:0] enc_a,
	input wire logic [1:0] enc_b,
	input wire logic [1:0] enc_z,
	input wire logic [1:0] second_index,
	input wire logic [1:0] aux_error,
	// aux track level codes, 0 to full scale
	input wire logic [7:0] aux_level_0,
	input wire logic [7:0] aux_level_1,
	// fault indications
	output logic [1:0] shearpin_fault,
	output logic [1:0] aux_fault,
	output logic [1:0] implausible,
	output logic [1:0] supervision_active
);
	import srm_pkg::*;

	logic [SRM_CTRL_W-1:0] ctrl [2];
	logic [31:0] ratio [2];
	logic [15:0] vlim [2];
	logic [1:0] speed_ok;
	logic [SRM_TIMER_W-1:0] timer [2];
	logic [3:0] warm [2];
	logic signed [40:0] acc [2];
	logic [1:0] a_level, a_rise;
	logic [1:0] b_level;
	logic [1:0] z_rise, s_rise, e_level;
	logic [1:0] ab_pulse, idx_pulse, ref_pulse, warm_pulse;
	logic [1:0] ratio_hi, run, warm_done, shear_set, aux_set;
	logic [1:0] shear_clr, aux_clr;
	logic [40:0] tol [2];
	logic [7:0] level [2];
	logic wr, rd_setup;
	logic [31:0] next_prdata;
	logic next_pslverr;

	function automatic logic [40:0] srm_abs(input logic signed [40:0] v);
		srm_abs = v[40] ? 41'(-v) : 41'(v);
	endfunction

	function automatic logic [31:0] srm_merge(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		srm_merge = r;
	endfunction

	// pin synchronisers
	for (genvar g = 0; g < 2; g++) begin : g_sync
		srm_pin_sync u_a (
			.pclk(pclk),
			.presetn(presetn),
			.pin(enc_a[g]),
			.level(a_level[g]),
			.rise(a_rise[g])
		);
		srm_pin_sync u_b (
			.pclk(pclk),
			.presetn(presetn),
			.pin(enc_b[g]),
			.level(b_level[g]),
			.rise()
		);
		srm_pin_sync u_z (
			.pclk(pclk),
			.presetn(presetn),
			.pin(enc_z[g]),
			.level(),
			.rise(z_rise[g])
		);
		srm_pin_sync u_s (
			.pclk(pclk),
			.presetn(presetn),
			.pin(second_index[g]),
			.level(),
			.rise(s_rise[g])
		);
		srm_pin_sync u_e (
			.pclk(pclk),
			.presetn(presetn),
			.pin(aux_error[g]),
			.level(e_level[g]),
			.rise()
		);
	end

	assign level[0] = aux_level_0;
	assign level[1] = aux_level_1;

	// per-axis pulse routing and thresholds
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ab_pulse[i] = a_rise[i];
			// z ignored unless an index source is configured
			// source: track z (index or proximity switch) or second sensor
			idx_pulse[i] = ctrl[i][SRM_CTRL_IDX_BIT] &
				(ctrl[i][SRM_CTRL_SECOND_BIT] ? s_rise[i] : z_rise[i]);
			ratio_hi[i] = ratio[i] >= SRM_RATIO_ONE;
			// reference track for the speed limit
			ref_pulse[i] = ratio_hi[i] ? idx_pulse[i] : ab_pulse[i];
			warm_pulse[i] = ref_pulse[i];
			// tolerance in ab pulses, q16.16
			tol[i] = ratio_hi[i] ?
				41'((41'(ratio[i]) * SRM_TOL_HI_HALVES) >> 1) :
				SRM_TOL_LO_AB;
			warm_done[i] = warm[i] >=
				(ratio_hi[i] ? SRM_WARM_HI_Z : SRM_WARM_LO_AB);
			run[i] = ctrl[i][SRM_CTRL_EN_BIT] &
				ctrl[i][SRM_CTRL_IDX_BIT] & speed_ok[i];
			shear_set[i] = run[i] & warm_done[i] &
				(srm_abs(acc[i]) > tol[i]);
			aux_set[i] = 1'b0;
			case (srm_aux_type'(ctrl[i][SRM_CTRL_MODE_LSB +: 2]))
				SRM_AUX_ERROR: begin
					aux_set[i] = ctrl[i][SRM_CTRL_EN_BIT] &
						(e_level[i] == ctrl[i][SRM_CTRL_ERRPOL_BIT]);
				end
				SRM_AUX_VOLTAGE: begin
					aux_set[i] = ctrl[i][SRM_CTRL_EN_BIT] &
						((level[i] > vlim[i][SRM_VLIM_HI_LSB +: 8]) |
						(level[i] < vlim[i][SRM_VLIM_LO_LSB +: 8]));
				end
				default: begin
					aux_set[i] = 1'b0;
				end
			endcase
		end
	end

	// speed timer: cycles since the last reference pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				timer[i] <= '1;
			end
			speed_ok <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (ref_pulse[i]) begin
					timer[i] <= '0;
				end else if (timer[i] != '1) begin
					timer[i] <= timer[i] + 1'b1;
				end
				speed_ok[i] <= timer[i] < MIN_PERIOD_CYC;
			end
		end
	end

	// feasibility warm-up and ratio accumulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				warm[i] <= 4'h0;
				acc[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!run[i]) begin
					// below minimum speed the tolerance window restarts
					warm[i] <= 4'h0;
					acc[i] <= '0;
				end else begin
					if (warm_pulse[i] && !warm_done[i]) begin
						warm[i] <= warm[i] + 4'h1;
					end
					// ab pulse adds one, index pulse removes the ratio
					acc[i] <= acc[i] +
						(ab_pulse[i] ? 41'(1) << SRM_FRAC_BITS : 41'(0)) -
						(idx_pulse[i] ? 41'(ratio[i]) : 41'(0));
				end
			end
		end
	end

	// sticky faults, set wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shearpin_fault <= 2'b00;
			aux_fault <= 2'b00;
			implausible <= 2'b00;
			supervision_active <= 2'b00;
		end else begin
			shearpin_fault <= shear_set | (shearpin_fault & ~shear_clr);
			aux_fault <= aux_set | (aux_fault & ~aux_clr);
			implausible <= shear_set | aux_set |
				(shearpin_fault & ~shear_clr) | (aux_fault & ~aux_clr);
			supervision_active <= run & warm_done;
		end
	end

	// apb decode, zero wait states
	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			shear_clr[i] = wr & (paddr == SRM_STATUS_OFS) &
				pstrb[i] & pwdata[i*SRM_STAT_AXIS_STRIDE + SRM_STAT_SHEAR_BIT];
			aux_clr[i] = wr & (paddr == SRM_STATUS_OFS) &
				pstrb[i] & pwdata[i*SRM_STAT_AXIS_STRIDE + SRM_STAT_AUX_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				ctrl[i] <= SRM_CTRL_RST;
				ratio[i] <= SRM_RATIO_RST;
				vlim[i] <= SRM_VLIM_RST;
			end
		end else if (wr) begin
			case (paddr)
				SRM_CTRL0_OFS: begin
					ctrl[0] <= SRM_CTRL_W'(srm_merge(32'(ctrl[0]), pwdata, pstrb));
				end
				SRM_CTRL1_OFS: begin
					ctrl[1] <= SRM_CTRL_W'(srm_merge(32'(ctrl[1]), pwdata, pstrb));
				end
				SRM_RATIO0_OFS: begin
					ratio[0] <= srm_merge(ratio[0], pwdata, pstrb);
				end
				SRM_RATIO1_OFS: begin
					ratio[1] <= srm_merge(ratio[1], pwdata, pstrb);
				end
				SRM_VLIM0_OFS: begin
					vlim[0] <= 16'(srm_merge(32'(vlim[0]), pwdata, pstrb));
				end
				SRM_VLIM1_OFS: begin
					vlim[1] <= 16'(srm_merge(32'(vlim[1]), pwdata, pstrb));
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		case (paddr)
			SRM_CTRL0_OFS: next_prdata = 32'(ctrl[0]);
			SRM_CTRL1_OFS: next_prdata = 32'(ctrl[1]);
			SRM_RATIO0_OFS: next_prdata = ratio[0];
			SRM_RATIO1_OFS: next_prdata = ratio[1];
			SRM_VLIM0_OFS: next_prdata = 32'(vlim[0]);
			SRM_VLIM1_OFS: next_prdata = 32'(vlim[1]);
			SRM_STATUS_OFS: begin
				for (int i = 0; i < 2; i++) begin
					next_prdata[i*SRM_STAT_AXIS_STRIDE + SRM_STAT_SHEAR_BIT] =
						shearpin_fault[i];
					next_prdata[i*SRM_STAT_AXIS_STRIDE + SRM_STAT_AUX_BIT] =
						aux_fault[i];
					next_prdata[i*SRM_STAT_AXIS_STRIDE + SRM_STAT_ACTIVE_BIT] =
						supervision_active[i];
					next_prdata[i*SRM_STAT_AXIS_STRIDE + SRM_STAT_SPEED_BIT] =
						speed_ok[i];
				end
			end
			SRM_IDENT_OFS: next_prdata = SRM_IDENT;
			default: next_pslverr = 1'b1;
		endcase
	end

	// read data captured in the setup phase, valid through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
			pslverr <= next_pslverr;
		end else if (!psel) begin
			pslverr <= 1'b0;
		end
	end

	logic unused_b;
	assign unused_b = ^b_level;
endmodule // srm_monitor

/* tb/srm_asserts.sv */
`timescale 1ns/100ps
module srm_asserts (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// indications
	input wire logic [1:0] shearpin_fault,
	input wire logic [1:0] aux_fault,
	input wire logic [1:0] implausible,
	input wire logic [1:0] supervision_active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence acc_ph;
		psel && penable;
	endsequence
	sequence acc_wr;
		acc_ph ##0 pwrite;
	endsequence
	ready_always_a: assert property (pready)
		else $error("pready low");
	wr_zero_a: assert property (acc_wr |-> prdata == 32'h0)
		else $error("read data not zero on write");
	unmapped_err_a: assert property (acc_ph ##0 paddr > 8'h1C |-> pslverr)
		else $error("no error on unmapped access");
	err_in_xfer_a: assert property (pslverr |-> $past(psel))
		else $error("error outside transfer");
	implaus_or_a: assert property (
		implausible == (shearpin_fault | aux_fault))
		else $error("implausible mismatch");
	shear_active_a: assert property (
		(shearpin_fault & ~$past(shearpin_fault) & ~supervision_active) == 2'h0)
		else $error("fault while not supervising");
	shear_sticky_a: assert property (
		|(~shearpin_fault & $past(shearpin_fault)) |->
		$past(psel && penable && pwrite &&
		paddr == srm_pkg::SRM_STATUS_OFS))
		else $error("fault dropped without write");
	aux_sticky_a: assert property (
		|(~aux_fault & $past(aux_fault)) |->
		$past(psel && penable && pwrite &&
		paddr == srm_pkg::SRM_STATUS_OFS))
		else $error("aux fault dropped without write");
endmodule // srm_asserts

bind srm_monitor srm_asserts srm_asserts_inst (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .shearpin_fault,
	.aux_fault, .implausible, .supervision_active);

/* tb/srm_track.sv */
`timescale 1ns/100ps
module srm_track (
	// clock
	input wire logic pclk,
	// half period minus one, zero holds the track still
	input wire logic [7:0] a_half,
	input wire logic [7:0] z_half,
	// pulse tracks
	output logic a,
	output logic z
);
	logic [7:0] ca = 8'h00;
	logic [7:0] cz = 8'h00;
	initial begin
		a = 1'b0;
		z = 1'b0;
	end
	always @(posedge pclk) begin
		ca <= (ca >= a_half) ? 8'h00 : ca + 8'h01;
		cz <= (cz >= z_half) ? 8'h00 : cz + 8'h01;
		if (a_half != 8'h00 && ca >= a_half)
			a <= ~a;
		if (z_half != 8'h00 && cz >= z_half)
			z <= ~z;
	end
endmodule // srm_track

/* tb/shearpin_ratio_monitor_bench.sv */
`timescale 1ns/100ps
module shearpin_ratio_monitor_bench;
	import srm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic a0, z0, a1, z1;
	logic [7:0] paddr, ah0, zh0, ah1, zh1, aux_level_0, aux_level_1, lv;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [1:0] noise, aux_error, shearpin_fault, aux_fault, implausible;
	logic [1:0] supervision_active;
	logic [7:0] cor [6] = '{8'h40, 8'hC0, 8'hC1, 8'h3F, 8'h00, 8'hFF};
	int miscompares = 0;
	int n_checks = 0;
	int i;
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	srm_track srm_track_inst0 (.pclk, .a_half(ah0), .z_half(zh0), .a(a0),
		.z(z0));
	srm_track srm_track_inst1 (.pclk, .a_half(ah1), .z_half(zh1), .a(a1),
		.z(z1));
	srm_monitor #(.MIN_PERIOD_CYC(34'h7D0)) srm_monitor_inst (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .enc_a({a1, a0}), .enc_b(noise),
		.enc_z({noise[0], z0}), .second_index({z1, noise[1]}), .aux_error,
		.aux_level_0, .aux_level_1, .shearpin_fault, .aux_fault, .implausible,
		.supervision_active);
	always @(posedge pclk) begin
		noise <= 2'($urandom);
		aux_level_0 <= 8'($urandom);
	end
	function automatic logic out_of_range(input logic [7:0] c);
		return c > 8'hC0 || c < 8'h40;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		chk(32'(pready), 32'h1);
		{psel, penable} <= 2'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk(32'(e), 32'(xe));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic stop_test();
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h678638e5));
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = 48'h00F;
		{ah0, zh0, ah1, zh1, aux_level_1} = 40'h80;
		aux_error = 2'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(SRM_CTRL0_OFS, 32'(SRM_CTRL_RST), 1'b0);
		rd(SRM_RATIO1_OFS, SRM_RATIO_RST, 1'b0);
		rd(SRM_VLIM1_OFS, 32'(SRM_VLIM_RST), 1'b0);
		wr(SRM_IDENT_OFS, 32'h0);
		rd(SRM_IDENT_OFS, SRM_IDENT, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		wr(SRM_RATIO1_OFS, 32'h8000);
		wr(SRM_CTRL0_OFS, 32'h3);
		wr(SRM_CTRL1_OFS, 32'h7);
		{ah0, zh0, ah1, zh1} <= 32'h1414_2914;
		repeat (100) @(posedge pclk);
		chk(32'(supervision_active), 32'h0);
		for (i = 0; i < 1500 && supervision_active !== 2'h3; i++)
			@(posedge pclk);
		chk(32'(supervision_active), 32'h3);
		zh0 <= 8'h00;
		repeat (250) @(posedge pclk);
		chk(32'(shearpin_fault), 32'h0);
		for (i = 0; i < 500 && shearpin_fault[0] !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(shearpin_fault), 32'h1);
		zh1 <= 8'h00;
		for (i = 0; i < 600 && shearpin_fault[1] !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(implausible), 32'h3);
		for (i = 0; i < 3000 && supervision_active[0] !== 1'b0; i++)
			@(posedge pclk);
		chk(32'(supervision_active), 32'h2);
		rd(SRM_STATUS_OFS, 32'h0D01, 1'b0);
		wr(SRM_CTRL0_OFS, 32'h1);
		wr(SRM_CTRL1_OFS, 32'h0);
		wr(SRM_STATUS_OFS, 32'h0101);
		zh0 <= 8'h14;
		repeat (600) @(posedge pclk);
		chk(32'({supervision_active, shearpin_fault}), 32'h0);
		wr(SRM_CTRL0_OFS, 32'h29);
		repeat (20) @(posedge pclk);
		chk(32'(aux_fault), 32'h0);
		aux_error <= 2'h3;
		for (i = 0; i < 20 && aux_fault[0] !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(implausible), 32'h1);
		pstrb <= 4'h2;
		wr(SRM_STATUS_OFS, 32'h0002);
		pstrb <= 4'hF;
		rd(SRM_STATUS_OFS, 32'h0802, 1'b0);
		wr(SRM_CTRL0_OFS, 32'h19);
		wr(SRM_STATUS_OFS, 32'h0002);
		repeat (8) @(posedge pclk);
		chk(32'(aux_fault), 32'h0);
		aux_error <= 2'h2;
		wr(SRM_CTRL0_OFS, 32'h09);
		for (i = 0; i < 20 && aux_fault[0] !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(aux_fault), 32'h1);
		wr(SRM_VLIM1_OFS, 32'hC040);
		wr(SRM_CTRL1_OFS, 32'h11);
		for (i = 0; i < 24; i++) begin
			lv = (i < 6) ? cor[i] : 8'($urandom);
			aux_level_1 <= lv;
			repeat (4) @(posedge pclk);
			chk(32'(aux_fault[1]), 32'(out_of_range(lv)));
			aux_level_1 <= 8'h80;
			wr(SRM_STATUS_OFS, 32'h0200);
		end
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		stop_test();
	end
endmodule // shearpin_ratio_monitor_bench
